/* File: design/lpc_pkg.sv */
// constants for the lo path control and readback register block
package lpc_pkg;
    localparam int          ADDR_W          = 16;
    localparam int          DATA_W          = 8;
    localparam int          AUX_W           = 14;
    localparam int          WORD_W          = 24;
    localparam int          DIV_W           = 5;
    localparam int          DEPTH_W         = 2;
    localparam logic [15:0] OFS_LO_CTRL     = 16'h1414;
    localparam logic [15:0] OFS_AUX_LOW     = 16'h1541;
    localparam logic [15:0] OFS_AUX_HIGH    = 16'h1542;
    localparam logic [15:0] OFS_FINE_LOW    = 16'h1543;
    localparam logic [15:0] OFS_FINE_MID    = 16'h1544;
    localparam logic [15:0] OFS_FINE_HIGH   = 16'h1545;
    localparam logic [15:0] OFS_PHASE_LOW   = 16'h1546;
    localparam logic [15:0] OFS_PHASE_MID   = 16'h1547;
    localparam logic [15:0] OFS_PHASE_HIGH  = 16'h1548;
    localparam int          BIT_MIX_OE      = 7;
    localparam int          BIT_OSC_OE      = 6;
    localparam int          BIT_EXT_SEL     = 5;
    localparam int          DIV_LSB         = 0;
    localparam logic [7:0]  LO_CTRL_RST     = 8'h02;
    localparam logic [4:0]  DIV_MUTE        = 5'h00;
    localparam logic [13:0] AUX_RST         = 14'h0000;
    localparam logic [23:0] WORD_RST        = 24'h00_0000;
    localparam logic [7:0]  RDATA_NONE      = 8'h00;
endpackage : lpc_pkg

/* File: design/lpc_rb_if.sv */
// carrier between register logic and the double-buffered readback store
`timescale 1ns/1ps
`default_nettype none
interface lpc_rb_if;
    logic                               load;
    logic [lpc_pkg::AUX_W-1:0]          aux_live;
    logic [lpc_pkg::WORD_W-1:0]         fine_live;
    logic [lpc_pkg::WORD_W-1:0]         phase_live;
    logic [lpc_pkg::AUX_W-1:0]          aux_held;
    logic [lpc_pkg::WORD_W-1:0]         fine_held;
    logic [lpc_pkg::WORD_W-1:0]         phase_held;
    modport store (input load, aux_live, fine_live, phase_live,
                   output aux_held, fine_held, phase_held);
    modport regs  (output load, aux_live, fine_live, phase_live,
                   input aux_held, fine_held, phase_held);
endinterface : lpc_rb_if
`default_nettype wire

/* File: design/lpc_readback.sv */
// double-buffered tuning and phase word store
`timescale 1ns/1ps
`default_nettype none
module lpc_readback (
    input  wire logic   sys_clk,
    input  wire logic   rstn,
    lpc_rb_if.store     rb
);
    logic [lpc_pkg::AUX_W-1:0]  aux_r,   aux_nxt;
    logic [lpc_pkg::WORD_W-1:0] fine_r,  fine_nxt;
    logic [lpc_pkg::WORD_W-1:0] phase_r, phase_nxt;

    // only the synthesizer's update strobe moves the held words
    always_comb begin
        aux_nxt   = aux_r;
        fine_nxt  = fine_r;
        phase_nxt = phase_r;
        if (rb.load) begin
            aux_nxt   = rb.aux_live;
            fine_nxt  = rb.fine_live;
            phase_nxt = rb.phase_live;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            aux_r   <= lpc_pkg::AUX_RST;
            fine_r  <= lpc_pkg::WORD_RST;
            phase_r <= lpc_pkg::WORD_RST;
        end else begin
            aux_r   <= aux_nxt;
            fine_r  <= fine_nxt;
            phase_r <= phase_nxt;
        end
    end

    assign rb.aux_held   = aux_r;
    assign rb.fine_held  = fine_r;
    assign rb.phase_held = phase_r;
endmodule : lpc_readback
`default_nettype wire

/* File: design/lpc_regs.sv */
// lo path control register and double-buffered word readback registers
`timescale 1ns/1ps
`default_nettype none
module lpc_regs (
    input  wire logic                          sys_clk,
    input  wire logic                          rstn,
    input  wire logic [lpc_pkg::ADDR_W-1:0]    reg_addr,
    input  wire logic [lpc_pkg::DATA_W-1:0]    reg_wdata,
    input  wire logic                          reg_wr,
    input  wire logic                          reg_rd,
    output logic      [lpc_pkg::DATA_W-1:0]    reg_rdata_r,
    output logic                               reg_rvalid_r,
    input  wire logic                          mute_request,
    input  wire logic [lpc_pkg::DEPTH_W-1:0]   general_silence_depth,
    input  wire logic                          word_update,
    input  wire logic [lpc_pkg::AUX_W-1:0]     aux_modulus_word,
    input  wire logic [lpc_pkg::WORD_W-1:0]    fine_tuning_word,
    input  wire logic [lpc_pkg::WORD_W-1:0]    phase_word,
    output logic                               mixer_output_enable_r,
    output logic                               oscillator_output_enable_r,
    output logic                               external_source_select_r,
    output logic      [lpc_pkg::DIV_W-1:0]     output_divide_field_r,
    output logic                               mixer_mute_r,
    output logic                               oscillator_mute_r,
    output logic      [lpc_pkg::DEPTH_W-1:0]   silence_depth_r
);
    lpc_rb_if rb ();

    assign rb.load       = word_update;
    assign rb.aux_live   = aux_modulus_word;
    assign rb.fine_live  = fine_tuning_word;
    assign rb.phase_live = phase_word;

    lpc_readback u_readback (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .rb      (rb)
    );

    logic [7:0]                     ctrl_r,    ctrl_nxt;
    logic [lpc_pkg::DATA_W-1:0]     rdata_nxt;
    logic                           rvalid_nxt;
    logic                           mix_mute_nxt, osc_mute_nxt;
    logic                           ctrl_wr;
    logic [lpc_pkg::DIV_W-1:0]      div_nxt;

    assign ctrl_wr = reg_wr && (reg_addr == lpc_pkg::OFS_LO_CTRL);

    // control register; writes elsewhere, readback included, change nothing
    always_comb begin
        ctrl_nxt = ctrl_r;
        if (ctrl_wr) begin
            ctrl_nxt = reg_wdata;
        end
    end

    assign div_nxt = ctrl_nxt[lpc_pkg::DIV_LSB +: lpc_pkg::DIV_W];

    // mute follows the new setting in the same edge as the enables
    // a shared chain branch can leave less isolation than the depth asks
    always_comb begin
        mix_mute_nxt = !ctrl_nxt[lpc_pkg::BIT_MIX_OE] || mute_request
                       || (div_nxt == lpc_pkg::DIV_MUTE);
        osc_mute_nxt = !ctrl_nxt[lpc_pkg::BIT_OSC_OE] || mute_request
                       || (div_nxt == lpc_pkg::DIV_MUTE);
    end

    // read mux, answered one edge after the read strobe
    always_comb begin
        rvalid_nxt = reg_rd;
        rdata_nxt  = lpc_pkg::RDATA_NONE;
        if (reg_rd) begin
            case (reg_addr)
                lpc_pkg::OFS_LO_CTRL:    rdata_nxt = ctrl_r;
                lpc_pkg::OFS_AUX_LOW:    rdata_nxt = rb.aux_held[7:0];
                lpc_pkg::OFS_AUX_HIGH:   rdata_nxt = {2'b00, rb.aux_held[13:8]};
                lpc_pkg::OFS_FINE_LOW:   rdata_nxt = rb.fine_held[7:0];
                lpc_pkg::OFS_FINE_MID:   rdata_nxt = rb.fine_held[15:8];
                lpc_pkg::OFS_FINE_HIGH:  rdata_nxt = rb.fine_held[23:16];
                lpc_pkg::OFS_PHASE_LOW:  rdata_nxt = rb.phase_held[7:0];
                lpc_pkg::OFS_PHASE_MID:  rdata_nxt = rb.phase_held[15:8];
                lpc_pkg::OFS_PHASE_HIGH: rdata_nxt = rb.phase_held[23:16];
                default:                 rdata_nxt = lpc_pkg::RDATA_NONE;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_r                     <= lpc_pkg::LO_CTRL_RST;
            reg_rdata_r                <= lpc_pkg::RDATA_NONE;
            reg_rvalid_r               <= 1'b0;
            mixer_output_enable_r      <= lpc_pkg::LO_CTRL_RST[lpc_pkg::BIT_MIX_OE];
            oscillator_output_enable_r <= lpc_pkg::LO_CTRL_RST[lpc_pkg::BIT_OSC_OE];
            external_source_select_r   <= lpc_pkg::LO_CTRL_RST[lpc_pkg::BIT_EXT_SEL];
            output_divide_field_r      <= lpc_pkg::LO_CTRL_RST[4:0];
            mixer_mute_r               <= 1'b1;
            oscillator_mute_r          <= 1'b1;
            silence_depth_r            <= '0;
        end else begin
            ctrl_r                     <= ctrl_nxt;
            reg_rdata_r                <= rdata_nxt;
            reg_rvalid_r               <= rvalid_nxt;
            mixer_output_enable_r      <= ctrl_nxt[lpc_pkg::BIT_MIX_OE];
            oscillator_output_enable_r <= ctrl_nxt[lpc_pkg::BIT_OSC_OE];
            external_source_select_r   <= ctrl_nxt[lpc_pkg::BIT_EXT_SEL];
            output_divide_field_r      <= div_nxt;
            mixer_mute_r               <= mix_mute_nxt;
            oscillator_mute_r          <= osc_mute_nxt;
            silence_depth_r            <= general_silence_depth;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    chk_ctrl_after_reset: assert property (
        $rose(rstn) |-> output_divide_field_r == lpc_pkg::LO_CTRL_RST[4:0] && !mixer_output_enable_r)
        else $error("control outputs not at reset value");
    chk_write_whole_path: assert property (
        ctrl_wr |=> output_divide_field_r == $past(reg_wdata[4:0])
                    && external_source_select_r == $past(reg_wdata[5]))
        else $error("control write did not reach path outputs");
    chk_mixer_enable_bit: assert property (
        ctrl_wr |=> mixer_output_enable_r == $past(reg_wdata[7]))
        else $error("mixer enable not bit 7");
    chk_osc_enable_bit: assert property (
        ctrl_wr |=> oscillator_output_enable_r == $past(reg_wdata[6]))
        else $error("oscillator enable not bit 6");
    chk_mixer_mute_cause: assert property (
        ##1 mixer_mute_r == (!mixer_output_enable_r || $past(mute_request)
                             || output_divide_field_r == 5'h00))
        else $error("mixer mute does not match its causes");
    chk_osc_mute_cause: assert property (
        ##1 oscillator_mute_r == (!oscillator_output_enable_r || $past(mute_request)
                                  || output_divide_field_r == 5'h00))
        else $error("oscillator mute does not match its causes");
    chk_readback_write_ignored: assert property (
        reg_wr && reg_addr != lpc_pkg::OFS_LO_CTRL |=> $stable(ctrl_r))
        else $error("write outside control register changed it");
    chk_aux_high_read: assert property (
        reg_rd && reg_addr == lpc_pkg::OFS_AUX_HIGH |=> reg_rvalid_r
            && reg_rdata_r == {2'b00, $past(rb.aux_held[13:8])})
        else $error("aux high readback wrong");
    chk_fine_mid_read: assert property (
        reg_rd && reg_addr == lpc_pkg::OFS_FINE_MID
            |=> reg_rdata_r == $past(rb.fine_held[15:8]))
        else $error("fine middle readback wrong");
    chk_phase_low_read: assert property (
        word_update ##1 reg_rd && reg_addr == lpc_pkg::OFS_PHASE_LOW
            |=> reg_rdata_r == $past(phase_word[7:0], 2))
        else $error("phase low readback wrong");
    chk_phase_high_read: assert property (
        reg_rd && reg_addr == lpc_pkg::OFS_PHASE_HIGH
            |=> reg_rdata_r == $past(rb.phase_held[23:16]))
        else $error("phase high readback wrong");
    chk_aux_low_read: assert property (
        reg_rd && reg_addr == lpc_pkg::OFS_AUX_LOW
            |=> reg_rdata_r == $past(rb.aux_held[7:0]))
        else $error("aux low readback wrong");
    chk_fine_low_read: assert property (
        reg_rd && reg_addr == lpc_pkg::OFS_FINE_LOW
            |=> reg_rdata_r == $past(rb.fine_held[7:0]))
        else $error("fine low readback wrong");
    chk_fine_high_read: assert property (
        reg_rd && reg_addr == lpc_pkg::OFS_FINE_HIGH
            |=> reg_rdata_r == $past(rb.fine_held[23:16]))
        else $error("fine high readback wrong");
    chk_phase_mid_read: assert property (
        reg_rd && reg_addr == lpc_pkg::OFS_PHASE_MID
            |=> reg_rdata_r == $past(rb.phase_held[15:8]))
        else $error("phase middle readback wrong");
    chk_ctrl_readback: assert property (
        reg_rd && reg_addr == lpc_pkg::OFS_LO_CTRL
            |=> reg_rdata_r == $past(ctrl_r))
        else $error("control readback wrong");
    chk_ext_select_bit: assert property (
        ctrl_wr
            |=> external_source_select_r == $past(reg_wdata[lpc_pkg::BIT_EXT_SEL]))
        else $error("external select not bit 5");
    chk_divide_field_held: assert property (
        !ctrl_wr
            |=> $stable(output_divide_field_r))
        else $error("divide field moved without a control write");
    chk_read_valid_pulse: assert property (
        reg_rd
            |=> reg_rvalid_r)
        else $error("read not answered next cycle");
    chk_read_answer_once: assert property (
        !reg_rd
            |=> !reg_rvalid_r && reg_rdata_r == lpc_pkg::RDATA_NONE)
        else $error("read answer outside its cycle");
    chk_depth_follows: assert property (
        ##1 silence_depth_r == $past(general_silence_depth))
        else $error("silence depth not passed on");
    chk_held_word_steady: assert property (
        !word_update
            |=> $stable(rb.aux_held) && $stable(rb.fine_held) && $stable(rb.phase_held))
        else $error("held word moved without update");
    chk_mute_on_zero: assert property (
        output_divide_field_r == lpc_pkg::DIV_MUTE
            |-> mixer_mute_r && oscillator_mute_r)
        else $error("zero divide did not mute");
    chk_mixer_off_muted: assert property (
        !mixer_output_enable_r
            |-> mixer_mute_r)
        else $error("mixer disabled but not muted");
    chk_osc_off_muted: assert property (
        !oscillator_output_enable_r
            |-> oscillator_mute_r)
        else $error("oscillator disabled but not muted");
endmodule : lpc_regs
`default_nettype wire

/* File: sim/lpc_host.sv */
// host model driving the register strobe port
`timescale 1ns/1ps
`default_nettype none
module lpc_host (
    input  wire logic                       sys_clk,
    output logic [lpc_pkg::ADDR_W-1:0]      reg_addr,
    output logic [lpc_pkg::DATA_W-1:0]      reg_wdata,
    output logic                            reg_wr,
    output logic                            reg_rd
);
    initial begin
        reg_addr  = 16'h0000;
        reg_wdata = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
    end
    // one strobe cycle, then idle lines show the inverse
    task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        #1;
        reg_wr    = w;
        reg_rd    = !w;
        reg_addr  = a;
        reg_wdata = d;
        @(posedge sys_clk);
        #1;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_addr  = ~a;
        reg_wdata = ~d;
    endtask : acc
endmodule : lpc_host
`default_nettype wire

/* File: sim/lpc_regs_tb_top.sv */
// self-checking bench for the lo path register block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, x) begin n_tests++; if ((g) !== (x)) begin error_cnt++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, g, x); end end
module lpc_regs_tb_top;
    logic        sys_clk, rstn, mute_request, word_update, mix, osc, ext;
    logic [1:0]  depth;
    logic [13:0] aux, ha;
    logic [23:0] fine, phase, hf, hp;
    logic [15:0] reg_addr;
    logic [7:0]  reg_wdata, reg_rdata_r, e, ctl;
    logic        reg_wr, reg_rd, reg_rvalid_r, mix_oe, osc_oe, ext_sel, mix_m, osc_m;
    logic [4:0]  div_r, dv;
    logic [1:0]  depth_r;
    logic [7:0]  exp_q[$];
    logic [31:0] lfsr_s = 32'h5222_c57a;
    int          error_cnt = 0, n_tests = 0;
    logic [15:0] adr [9] = '{lpc_pkg::OFS_LO_CTRL, lpc_pkg::OFS_AUX_LOW, lpc_pkg::OFS_AUX_HIGH,
        lpc_pkg::OFS_FINE_LOW, lpc_pkg::OFS_FINE_MID, lpc_pkg::OFS_FINE_HIGH,
        lpc_pkg::OFS_PHASE_LOW, lpc_pkg::OFS_PHASE_MID, lpc_pkg::OFS_PHASE_HIGH};
    lpc_host lpc_host_i (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd));
    lpc_regs lpc_regs_i (.sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r),
        .reg_rvalid_r(reg_rvalid_r), .mute_request(mute_request),
        .general_silence_depth(depth), .word_update(word_update), .aux_modulus_word(aux),
        .fine_tuning_word(fine), .phase_word(phase), .mixer_output_enable_r(mix_oe),
        .oscillator_output_enable_r(osc_oe), .external_source_select_r(ext_sel),
        .output_divide_field_r(div_r), .mixer_mute_r(mix_m), .oscillator_mute_r(osc_m),
        .silence_depth_r(depth_r));
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        logic [31:0] v;
        v = s;
        repeat (32) v = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
        return v;
    endfunction : lfsr_next
    task automatic rnd();
        lfsr_s = lfsr_next(lfsr_s);
    endtask : rnd
    task automatic rd(input logic [15:0] a, input logic [7:0] x);
        exp_q.push_back(x);
        lpc_host_i.acc(1'b0, a, 8'h00);
    endtask : rd
    // readback of all nine places against the held snapshot
    task automatic rd_all(input logic [7:0] c);
        logic [7:0] ev [9];
        ev = '{c, ha[7:0], {2'b00, ha[13:8]}, hf[7:0], hf[15:8], hf[23:16],
            hp[7:0], hp[15:8], hp[23:16]};
        for (int i = 0; i < 9; i++) rd(adr[i], ev[i]);
    endtask : rd_all
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : finish_test
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        if (reg_rvalid_r === 1'b1) begin
            e = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hxx;
            `CHK(reg_rdata_r, e)
        end
    end
    initial begin
        repeat (3000) @(posedge sys_clk);
        error_cnt++;
        finish_test();
    end
    initial begin
        {rstn, mute_request, word_update, depth, aux, fine, phase} = '0;
        {ha, hf, hp} = '0;
        repeat (4) @(posedge sys_clk);
        #1 rstn = 1'b1;
        @(posedge sys_clk);
        #1;
        `CHK({mix_oe, osc_oe, ext_sel, div_r, mix_m, osc_m}, 10'h00b)
        rd_all(lpc_pkg::LO_CTRL_RST);
        $display("test reset values done");
        rnd();
        aux = lfsr_s[13:0];
        rnd();
        fine = lfsr_s[23:0];
        rnd();
        phase = lfsr_s[23:0];
        @(posedge sys_clk);
        #1 word_update = 1'b1;
        {ha, hf, hp} = {aux, fine, phase};
        // read strobe lands on the edge right after the update strobe
        fork
            rd(lpc_pkg::OFS_PHASE_LOW, phase[7:0]);
            begin
                @(posedge sys_clk);
                #1 word_update = 1'b0;
            end
        join
        rnd();
        aux = lfsr_s[13:0];
        fine = ~lfsr_s[23:0];
        phase = lfsr_s[31:8];
        rd_all(lpc_pkg::LO_CTRL_RST);
        for (int i = 1; i < 9; i++) lpc_host_i.acc(1'b1, adr[i], 8'hff);
        rd_all(lpc_pkg::LO_CTRL_RST);
        $display("test readback words done");
        for (int i = 0; i < 6; i++) begin
            rnd();
            {mix, osc, ext, mute_request, depth} = lfsr_s[5:0];
            dv = (i == 5) ? 5'h00 : 5'h01 << i;
            ctl = {mix, osc, ext, dv};
            lpc_host_i.acc(1'b1, lpc_pkg::OFS_LO_CTRL, ctl);
            @(posedge sys_clk);
            #1;
            `CHK({mix_oe, osc_oe, ext_sel, div_r}, ctl)
            `CHK(mix_m, !mix || mute_request || dv == 5'h00)
            `CHK(osc_m, !osc || mute_request || dv == 5'h00)
            `CHK(depth_r, depth)
            rd(lpc_pkg::OFS_LO_CTRL, ctl);
        end
        repeat (3) @(posedge sys_clk);
        $display("test control register done");
        `CHK(exp_q.size(), 0)
        finish_test();
    end
endmodule : lpc_regs_tb_top
`default_nettype wire
